// >>> logic/cpu_transfer_arith_unit.sv
// Top: APB-driven transfer and arithmetic datapath with a word/byte memory request port
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module cpu_transfer_arith_unit (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [xfer_arith_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic mem_req,
   output logic mem_we,
   output logic mem_word,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_wdata,
   input wire logic [15:0] mem_rdata,
   input wire logic mem_ack
);
   import xfer_arith_pkg::*;

   typedef enum logic [1:0] {IDLE, EXEC, MEM_WAIT} state_t;

   logic [1:0] rst_pipe;
   logic rst_n;
   logic [15:0] gr [0:7];
   logic [3:0] flags;
   logic [CMD_W-1:0] cmd;
   logic [15:0] operand;
   logic err;
   state_t state;
   logic [15:0] ptr_new;
   logic [2:0] ptr_idx;
   logic ptr_upd;
   op_code_t op;
   addr_mode_t mode;
   addr_mode_t eff_mode;
   logic is_stack;
   logic word;
   logic store;
   logic muldiv;
   logic mem_mode;
   logic illegal;
   logic [3:0] rd_sel;
   logic [3:0] rs_sel;
   logic [2:0] areg;
   logic [15:0] base;
   logic [15:0] step;
   logic [15:0] ea;
   logic [15:0] ea_even;
   logic setup;
   logic wr_fire;
   logic go;
   logic gr_hit;
   logic busy;
   logic addr_bad;
   logic [31:0] rdata_mux;
   logic [15:0] stack_ptr;
   logic [15:0] dest_word;
   logic [7:0] dest_lo;
   logic [7:0] src_lo;
   logic [15:0] mul_ref;

   alu_calc_if alu_bus ();

   alu_calc u_alu (
      .port_c(alu_bus.core)
   );

   // Read a general register as a word, or one byte half zero-extended
   function automatic logic [15:0] reg_read(input logic [15:0] w, input logic [3:0] sel,
      input logic wide);
      if (wide) return w;
      return {8'h00, sel[BYTE_LO_BIT] ? w[7:0] : w[15:8]};
   endfunction : reg_read

   // Merge a byte or word result into a register word
   function automatic logic [15:0] reg_merge(input logic [15:0] w, input logic [15:0] v,
      input logic [3:0] sel, input logic wide);
      if (wide) return v;
      return sel[BYTE_LO_BIT] ? {w[15:8], v[7:0]} : {v[7:0], w[7:0]};
   endfunction : reg_merge

   // Reset release through two flops; only the second feeds the design
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // Command decode
   assign op = op_code_t'(cmd[CMD_OP_LSB +: OP_W]);
   assign mode = addr_mode_t'(cmd[CMD_MODE_LSB +: MODE_W]);
   assign rd_sel = cmd[CMD_RD_LSB +: 4];
   assign rs_sel = cmd[CMD_RS_LSB +: 4];
   assign is_stack = (op == OP_PUSH) || (op == OP_POP);
   assign word = cmd[CMD_WORD_BIT] || is_stack;
   assign store = (op == OP_PUSH) || ((op == OP_MOVE) && cmd[CMD_STORE_BIT]);
   assign muldiv = (op == OP_MUL_U) || (op == OP_DIV_U);
   assign mem_mode = is_stack || ((op == OP_MOVE) && (mode != MODE_REG) && (mode != MODE_IMM));
   assign busy = (state != IDLE);

   // Refuse forms the hardware does not offer; unknown codes fall in the default
   always_comb begin
      illegal = (cmd[CMD_OP_LSB +: OP_W] > OP_LAST);
      case (op)
         OP_MOVE: illegal |= ((mode == MODE_ABS8) && word) || (store && (mode == MODE_IMM));
         OP_PUSH, OP_POP: illegal |= 1'b0;
         OP_SUM, OP_COMPARE: illegal |= word ? (mode != MODE_REG)
            : ((mode != MODE_REG) && (mode != MODE_IMM));
         OP_DIFF: illegal |= (mode != MODE_REG);
         OP_SUM_CARRY, OP_DIFF_BORROW: illegal |= word || ((mode != MODE_REG)
            && (mode != MODE_IMM));
         OP_STEP_UP, OP_STEP_DOWN: illegal |= !word || (mode != MODE_IMM)
            || ((operand != STEP_BYTE) && (operand != STEP_WORD));
         default: illegal |= word || (mode != MODE_REG);
      endcase
   end

   // Effective address; stack operations use the stack register in fixed modes
   assign areg = is_stack ? STACK_INDEX : (store ? rd_sel[2:0] : rs_sel[2:0]);
   assign eff_mode = (op == OP_PUSH) ? MODE_PREDEC : ((op == OP_POP) ? MODE_POSTINC : mode);
   assign base = gr[areg];
   assign step = word ? STEP_WORD : STEP_BYTE;
   always_comb begin
      unique case (eff_mode)
         MODE_DISP: ea = base + operand;
         MODE_PREDEC: ea = base - step;
         MODE_ABS8: ea = {ABS8_PAGE, operand[7:0]};
         MODE_ABS16: ea = operand;
         MODE_REG, MODE_IND, MODE_POSTINC, MODE_IMM: ea = base;
      endcase
   end
   assign ea_even = word ? (ea & EVEN_MASK) : ea;

   // Operand routing to the core; in MEM_WAIT the memory side supplies the data
   always_comb begin
      alu_bus.op = op;
      alu_bus.word = word;
      alu_bus.flags_in = flags;
      alu_bus.a = muldiv ? gr[rd_sel[2:0]] : reg_read(gr[rd_sel[2:0]], rd_sel, word);
      if (state == MEM_WAIT) begin
         alu_bus.b = store ? mem_wdata : (word ? mem_rdata : {8'h00, mem_rdata[7:0]});
      end else if (mode == MODE_IMM) begin
         alu_bus.b = word ? operand : {8'h00, operand[7:0]};
      end else begin
         alu_bus.b = reg_read(gr[rs_sel[2:0]], rs_sel, word);
      end
   end

   // APB decode; writes while busy are refused so the command cannot shift mid-flight
   assign setup = psel && !penable;
   assign wr_fire = psel && penable && pready && pwrite && !pslverr;
   assign gr_hit = (paddr[7:5] == GR_PAGE) && (paddr[1:0] == 2'b00);
   assign go = wr_fire && (paddr == ADDR_CTRL) && pwdata[CTRL_GO_BIT];
   always_comb begin
      rdata_mux = 32'h00000000;
      addr_bad = 1'b0;
      case (paddr)
         ADDR_CMD: rdata_mux[CMD_W-1:0] = cmd;
         ADDR_OPERAND: rdata_mux[15:0] = operand;
         ADDR_CTRL: rdata_mux = 32'h00000000; // Go is a pulse, reads as zero
         ADDR_STATUS: begin
            rdata_mux[STAT_BUSY_BIT] = busy;
            rdata_mux[STAT_ERR_BIT] = err;
            rdata_mux[STAT_FLAG_LSB +: 4] = flags;
            addr_bad = pwrite;
         end
         default: begin
            addr_bad = !gr_hit;
            if (gr_hit) rdata_mux[15:0] = gr[paddr[4:2]];
         end
      endcase
      if (pwrite && busy) addr_bad = 1'b1;
   end

   // APB answer: ready one cycle after setup, so every access takes two cycles
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (ce) begin
         pready <= setup;
         pslverr <= setup && addr_bad;
         if (setup && !pwrite) prdata <= rdata_mux;
      end
   end

   // Command and operand registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cmd <= CMD_RESET;
         operand <= GR_RESET;
      end else if (ce && wr_fire) begin
         if (paddr == ADDR_CMD) cmd <= pwdata[CMD_W-1:0];
         if (paddr == ADDR_OPERAND) operand <= pwdata[15:0];
      end
   end

   // General registers: software writes, arithmetic results, pointer steps, loads
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 8; i++) gr[i] <= GR_RESET;
      end else if (ce) begin
         if (wr_fire && gr_hit) gr[paddr[4:2]] <= pwdata[15:0];
         if ((state == EXEC) && !mem_mode && alu_bus.write_dest) begin
            gr[rd_sel[2:0]] <= reg_merge(gr[rd_sel[2:0]], alu_bus.result, rd_sel,
               word || muldiv);
         end
         if ((state == MEM_WAIT) && mem_ack) begin
            if (ptr_upd) gr[ptr_idx] <= ptr_new;
            if (!store) gr[rd_sel[2:0]] <= reg_merge(gr[rd_sel[2:0]], alu_bus.result, rd_sel,
               word);
         end
      end
   end

   // Flag register: loaded from the core whenever an operation completes
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= FLAGS_RESET;
      end else if (ce) begin
         if (((state == EXEC) && !mem_mode) || ((state == MEM_WAIT) && mem_ack)) begin
            flags <= alu_bus.flags_out;
         end
      end
   end

   // Sequencer and memory request; the request holds until the memory acknowledges
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= IDLE;
         err <= 1'b0;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_word <= 1'b0;
         mem_addr <= GR_RESET;
         mem_wdata <= GR_RESET;
         ptr_new <= GR_RESET;
         ptr_idx <= STACK_INDEX;
         ptr_upd <= 1'b0;
      end else if (ce) begin
         unique case (state)
            IDLE: begin
               if (go) begin
                  err <= illegal;
                  if (!illegal) state <= EXEC;
               end
            end
            EXEC: begin
               if (mem_mode) begin
                  mem_req <= 1'b1;
                  mem_we <= store;
                  mem_word <= word;
                  mem_addr <= ea_even;
                  mem_wdata <= alu_bus.b;
                  ptr_idx <= areg;
                  ptr_upd <= (eff_mode == MODE_POSTINC) || (eff_mode == MODE_PREDEC);
                  ptr_new <= (eff_mode == MODE_POSTINC) ? base + step : base - step;
                  state <= MEM_WAIT;
               end else begin
                  state <= IDLE;
               end
            end
            MEM_WAIT: begin
               if (mem_ack) begin
                  mem_req <= 1'b0;
                  mem_we <= 1'b0;
                  state <= IDLE;
               end
            end
         endcase
      end
   end

   // Helper views for the checks below
   assign stack_ptr = gr[STACK_INDEX];
   assign dest_word = gr[rd_sel[2:0]];
   assign dest_lo = rd_sel[BYTE_LO_BIT] ? dest_word[7:0] : dest_word[15:8];
   assign src_lo = rs_sel[BYTE_LO_BIT] ? gr[rs_sel[2:0]][7:0] : gr[rs_sel[2:0]][15:8];
   assign mul_ref = {8'h00, dest_word[7:0]} * {8'h00, src_lo};

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_push_issue;
      ce && (state == EXEC) && (op == OP_PUSH);
   endsequence
   sequence s_pop_done;
      ce && (state == MEM_WAIT) && (op == OP_POP) && mem_ack && (rd_sel[2:0] != STACK_INDEX);
   endsequence

   property p_push_addr;
      s_push_issue |=> mem_req && mem_we && mem_word
         && (mem_addr == (($past(stack_ptr) - STEP_WORD) & EVEN_MASK));
   endproperty
   a_push_addr: assert property (p_push_addr) else $error("push address wrong");

   property p_pop_step;
      s_pop_done |=> (stack_ptr == $past(stack_ptr) + STEP_WORD) && (state == IDLE);
   endproperty
   a_pop_step: assert property (p_pop_step) else $error("pop did not raise pointer");

   property p_word_even;
      mem_req && mem_word |-> !mem_addr[0];
   endproperty
   a_word_even: assert property (p_word_even) else $error("odd word address");

   property p_abs8_page;
      ce && (state == EXEC) && (op == OP_MOVE) && (mode == MODE_ABS8)
         |=> mem_req && (mem_addr[15:8] == ABS8_PAGE);
   endproperty
   a_abs8_page: assert property (p_abs8_page) else $error("short page wrong");

   property p_abs8_refused;
      ce && go && (op == OP_MOVE) && (mode == MODE_ABS8) && word |=> err && (state == IDLE);
   endproperty
   a_abs8_refused: assert property (p_abs8_refused) else $error("short word move taken");

   property p_diff_imm_refused;
      ce && go && (op == OP_DIFF) && (mode == MODE_IMM) |=> err && !busy ##1 !mem_req;
   endproperty
   a_diff_imm_refused: assert property (p_diff_imm_refused) else $error("imm diff");

   property p_compare_keeps;
      ce && (state == EXEC) && (op == OP_COMPARE) |=> $stable(dest_word) && (state == IDLE);
   endproperty
   a_compare_keeps: assert property (p_compare_keeps) else $error("compare wrote");

   property p_negate;
      ce && (state == EXEC) && (op == OP_NEGATE) |=> dest_lo == (8'h00 - $past(dest_lo));
   endproperty
   a_negate: assert property (p_negate) else $error("negate result wrong");

   property p_mul;
      ce && (state == EXEC) && (op == OP_MUL_U) |=> dest_word == $past(mul_ref);
   endproperty
   a_mul: assert property (p_mul) else $error("product wrong");
endmodule : cpu_transfer_arith_unit
`default_nettype wire

// >>> logic/xfer_arith_pkg.sv
// Package: register map, field layout, codes and types of the transfer/arithmetic unit
// What this block does
// - Unit carries the transfer and arithmetic groups of a 55-type instruction set
// - Push lowers the stack pointer by two, then stores a register word there
// - Pop loads a register word from the stack pointer, then raises it by two
// - Moves cover register, memory and immediate forms in eight addressing modes
// - The short 8-bit absolute mode moves bytes only; word size is refused
// - Sum and difference use two registers; only the sum accepts an immediate
// - Word sum and difference exist only with both operands in registers
// - Carry sum and borrow difference combine byte operands with the carry flag
// - Plus-one and minus-one step a byte register by one in place
// - Pointer steps add or subtract one or two on a word register
// - Decimal fixes correct a byte to packed BCD using the current flags
// - Unsigned multiply takes two bytes and writes a 16-bit product
// - Unsigned divide splits a word by a byte into quotient and remainder
// - Compare subtracts and updates flags only, destination stays unchanged
// - Word compare only between registers; byte compare may use an immediate
// - Negate replaces a byte register with zero minus its value
// - Flag register holds negative, zero, overflow and carry, read by later ops
// - Every word access forces address bit zero low
// - Post-increment and pre-decrement step by one for bytes, two for words
// - Short absolute addresses take all ones in the upper eight bits
package xfer_arith_pkg;
   // APB byte addresses
   localparam int APB_AW = 8;
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_OPERAND = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [2:0] GR_PAGE = 3'h1; // 0x20..0x3C, one word per general register
   // Command word layout
   localparam int CMD_W = 20;
   localparam int OP_W = 5;
   localparam int MODE_W = 3;
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_WORD_BIT = 5;
   localparam int CMD_STORE_BIT = 6;
   localparam int CMD_MODE_LSB = 8;
   localparam int CMD_RD_LSB = 12;
   localparam int CMD_RS_LSB = 16;
   localparam int BYTE_LO_BIT = 3; // Byte select: 0 high half, 1 low half
   localparam int CTRL_GO_BIT = 0;
   // Status layout
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_ERR_BIT = 1;
   localparam int STAT_FLAG_LSB = 4;
   // Flag positions
   localparam int FLAG_C = 0;
   localparam int FLAG_V = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_N = 3;
   // Reset values and address constants
   localparam logic [CMD_W-1:0] CMD_RESET = 20'h00000;
   localparam logic [15:0] GR_RESET = 16'h0000;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam logic [7:0] ABS8_PAGE = 8'hFF;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   localparam logic [15:0] EVEN_MASK = 16'hFFFE;
   localparam logic [2:0] STACK_INDEX = 3'h7;

   typedef enum logic [4:0] {
      OP_MOVE, OP_PUSH, OP_POP, OP_SUM, OP_DIFF, OP_SUM_CARRY, OP_DIFF_BORROW,
      OP_PLUS_ONE, OP_MINUS_ONE, OP_STEP_UP, OP_STEP_DOWN, OP_BCD_SUM, OP_BCD_DIFF,
      OP_MUL_U, OP_DIV_U, OP_COMPARE, OP_NEGATE
   } op_code_t;
   localparam op_code_t OP_LAST = OP_NEGATE;

   typedef enum logic [2:0] {
      MODE_REG, MODE_IND, MODE_DISP, MODE_POSTINC, MODE_PREDEC, MODE_ABS8, MODE_ABS16, MODE_IMM
   } addr_mode_t;
endpackage : xfer_arith_pkg

// >>> logic/alu_calc_if.sv
// Interface: operands and results passed between the sequencer and the arithmetic core
`timescale 1ns/100ps
`default_nettype none
interface alu_calc_if;
   import xfer_arith_pkg::*;
   op_code_t op;
   logic word;
   logic [15:0] a;
   logic [15:0] b;
   logic [3:0] flags_in;
   logic [15:0] result;
   logic [3:0] flags_out;
   logic write_dest;
   modport core (input op, word, a, b, flags_in, output result, flags_out, write_dest);
   modport seq (output op, word, a, b, flags_in, input result, flags_out, write_dest);
endinterface : alu_calc_if
`default_nettype wire

// >>> logic/alu_calc.sv
// Module: combinational arithmetic core with flag generation
`timescale 1ns/100ps
`default_nettype none
module alu_calc (
   alu_calc_if.core port_c
);
   import xfer_arith_pkg::*;

   // Add or subtract at byte or word width, returns {carry, overflow, result}
   function automatic logic [17:0] add_sub(input logic [15:0] x, input logic [15:0] y,
      input logic cin, input logic sub, input logic word);
      logic [15:0] yy;
      logic [16:0] s;
      logic [8:0] sb;
      yy = sub ? ~y : y;
      s = {1'b0, x} + {1'b0, yy} + {16'h0000, cin ^ sub};
      sb = {1'b0, x[7:0]} + {1'b0, yy[7:0]} + {8'h00, cin ^ sub};
      if (word) begin
         return {s[16] ^ sub, (x[15] == yy[15]) && (s[15] != x[15]), s[15:0]};
      end
      return {sb[8] ^ sub, (x[7] == yy[7]) && (sb[7] != x[7]), 8'h00, sb[7:0]};
   endfunction : add_sub

   // Negative and zero at the width in use
   function automatic logic [1:0] neg_zero(input logic [15:0] r, input logic word);
      return word ? {r[15], r == 16'h0000} : {r[7], r[7:0] == 8'h00};
   endfunction : neg_zero

   logic [17:0] arith;
   logic use_arith;
   logic [7:0] adj;
   logic [15:0] quot;
   logic [15:0] rem;
   logic c_in;

   assign c_in = port_c.flags_in[FLAG_C];

   // Operation select; borrow is carried as an inverted carry inside add_sub
   always_comb begin
      arith = 18'h00000;
      use_arith = 1'b1;
      adj = 8'h00;
      quot = 16'h0000;
      rem = 16'h0000;
      port_c.result = port_c.b;
      port_c.flags_out = port_c.flags_in;
      port_c.write_dest = 1'b1;
      unique case (port_c.op)
         OP_MOVE, OP_PUSH, OP_POP: begin
            use_arith = 1'b0;
            port_c.flags_out = {neg_zero(port_c.b, port_c.word), 1'b0, c_in};
         end
         OP_SUM: arith = add_sub(port_c.a, port_c.b, 1'b0, 1'b0, port_c.word);
         OP_DIFF: arith = add_sub(port_c.a, port_c.b, 1'b0, 1'b1, port_c.word);
         OP_COMPARE: begin
            arith = add_sub(port_c.a, port_c.b, 1'b0, 1'b1, port_c.word);
            port_c.write_dest = 1'b0;
         end
         OP_SUM_CARRY: arith = add_sub(port_c.a, port_c.b, c_in, 1'b0, 1'b0);
         OP_DIFF_BORROW: arith = add_sub(port_c.a, port_c.b, c_in, 1'b1, 1'b0);
         OP_PLUS_ONE: arith = add_sub(port_c.a, STEP_BYTE, 1'b0, 1'b0, 1'b0);
         OP_MINUS_ONE: arith = add_sub(port_c.a, STEP_BYTE, 1'b0, 1'b1, 1'b0);
         OP_NEGATE: arith = add_sub(16'h0000, port_c.a, 1'b0, 1'b1, 1'b0);
         OP_STEP_UP: begin
            use_arith = 1'b0;
            port_c.result = port_c.a + port_c.b;
         end
         OP_STEP_DOWN: begin
            use_arith = 1'b0;
            port_c.result = port_c.a - port_c.b;
         end
         OP_BCD_SUM: begin
            use_arith = 1'b0;
            if (c_in || port_c.a[7:0] > 8'h99) adj = 8'h60;
            if (port_c.a[3:0] > 4'h9) adj = adj | 8'h06;
            port_c.result = {8'h00, port_c.a[7:0] + adj};
            port_c.flags_out = {neg_zero(port_c.result, 1'b0), port_c.flags_in[FLAG_V],
               c_in || adj[6]};
         end
         OP_BCD_DIFF: begin
            use_arith = 1'b0;
            if (c_in) adj = 8'h60;
            if (port_c.a[3:0] > 4'h9) adj = adj | 8'h06;
            port_c.result = {8'h00, port_c.a[7:0] - adj};
            port_c.flags_out = {neg_zero(port_c.result, 1'b0), port_c.flags_in[FLAG_V], c_in};
         end
         OP_MUL_U: begin
            use_arith = 1'b0;
            port_c.result = {8'h00, port_c.a[7:0]} * {8'h00, port_c.b[7:0]};
            port_c.flags_out = {neg_zero(port_c.result, 1'b1), 2'b00};
         end
         OP_DIV_U: begin
            use_arith = 1'b0;
            // A zero divisor leaves the destination alone and raises overflow
            if (port_c.b[7:0] == 8'h00) begin
               port_c.write_dest = 1'b0;
               port_c.flags_out = {2'b00, 1'b1, 1'b0};
            end else begin
               quot = port_c.a / {8'h00, port_c.b[7:0]};
               rem = port_c.a % {8'h00, port_c.b[7:0]};
               port_c.result = {rem[7:0], quot[7:0]};
               port_c.flags_out = {neg_zero(quot, 1'b0), quot[15:8] != 8'h00, 1'b0};
            end
         end
         default: use_arith = 1'b0; // Codes past the last op are refused before they run
      endcase
      if (use_arith) begin
         if (port_c.op != OP_COMPARE) port_c.result = arith[15:0];
         port_c.flags_out = {neg_zero(arith[15:0], port_c.word), arith[16], arith[17]};
      end
   end
endmodule : alu_calc
`default_nettype wire

// >>> test/mem_model.sv
// Memory bus partner: answers requests after a varying wait
`timescale 1ns/100ps
`default_nettype none
module mem_model (
   input wire logic mclk,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic mem_word,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   output logic [15:0] mem_rdata = 16'h0000,
   output logic mem_ack = 1'b0
);
   logic [15:0] m [0:65535];
   logic [1:0] cnt = 2'h0;
   // Data lines scramble between answers so stale data is never trusted
   always_ff @(posedge mclk) begin
      cnt <= cnt + 2'h1;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && cnt[1]) begin
         mem_ack <= 1'b1;
         if (mem_we) m[mem_addr] <= mem_word ? mem_wdata : {8'h00, mem_wdata[7:0]};
         else mem_rdata <= m[mem_addr];
      end
   end
endmodule : mem_model
`default_nettype wire

// >>> test/cpu_transfer_arith_unit_tb.sv
// Testbench: APB-driven checks of transfers, arithmetic and refusals
`timescale 1ns/100ps
`default_nettype none
module cpu_transfer_arith_unit_tb;
   import xfer_arith_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, mem_req, mem_we, mem_word, mem_ack, e, cf;
   logic [15:0] mem_addr, mem_wdata, mem_rdata, a, b, n;
   logic [16:0] x;
   logic [4:0] op;
   logic [4:0] ops [12] = '{3, 5, 4, 6, 7, 8, 15, 16, 13, 9, 14, 10};
   int num_errors = 0, samples_checked = 0, cyc = 0, seed = 32'h64BA;
   cpu_transfer_arith_unit DUT (.mclk(mclk), .rst_b(rst_b), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
      .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   mem_model mem (.mclk(mclk), .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   initial begin
      forever #50 mclk = ~mclk;
   end
   // Hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   // One APB transfer; answer taken at the rising edge that samples pready high
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= d;
      @(posedge mclk) penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic gr(input logic w, input logic [2:0] r, input logic [15:0] v);
      apb(w, 8'h20 + {3'h0, r, 2'b00}, {16'h0, v});
   endtask : gr
   task automatic run(input logic [31:0] c, input logic [15:0] o);
      apb(1'b1, ADDR_CMD, c); apb(1'b1, ADDR_OPERAND, {16'h0, o}); apb(1'b1, ADDR_CTRL, 32'h1);
      do apb(1'b0, ADDR_STATUS, 32'h0); while (q[STAT_BUSY_BIT] === 1'b1);
   endtask : run
   function automatic logic [31:0] cmd(input logic [4:0] o, input logic w, input logic s,
         input logic [2:0] m, input logic [3:0] rd, input logic [3:0] rs);
      return {12'h000, rs, rd, 1'b0, m, 1'b0, s, w, o};
   endfunction : cmd
   // Expected {carry, register} after one operation
   function automatic logic [16:0] calc(input logic [4:0] o, input logic [15:0] a,
         input logic [15:0] b, input logic c, input logic [15:0] n);
      logic [8:0] t;
      case (o)
         3: t = a[7:0] + b[7:0];
         4, 15: t = a[7:0] - b[7:0];
         5: t = a[7:0] + b[7:0] + c;
         6: t = a[7:0] - b[7:0] - c;
         7: t = a[7:0] + 1;
         8: t = a[7:0] - 1;
         16: t = 0 - a[7:0];
         9: return {1'b0, a + n};
         10: return {1'b0, a - n};
         13: return {1'b0, {8'h00, a[7:0]} * {8'h00, b[7:0]}};
         default: return {1'b0, 8'(a % b[7:0]), 8'(a / b[7:0])};
      endcase
      return {t[8], a[15:8], o == 15 ? a[7:0] : t[7:0]};
   endfunction : calc
   initial begin
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      apb(1'b0, ADDR_STATUS, 32'h0); check(q[7:4], FLAGS_RESET);
      apb(1'b0, 8'h14, 32'h0); check(e, 1'b1);
      $display("reset test done");
      cf = 1'b0;
      for (int i = 0; i < 24; i++) begin
         op = ops[i % 12]; a = $random(seed); b = $random(seed); b[0] = 1'b1;
         a[15:8] = a[15:8] % b[7:0]; n = {14'h0, i[1], ~i[1]};
         gr(1'b1, 3'h1, a); gr(1'b1, 3'h2, b);
         x = calc(op, a, b, cf, n);
         run(cmd(op, op == 9 || op == 10, 1'b0, (op == 9 || op == 10) ? 3'h7 : 3'h0, 4'h9, 4'hA), n);
         if (op < 9 || op > 14) begin
            check(q[4], x[16]);
            check(q[6], (op == 15) ? a[7:0] == b[7:0] : x[7:0] == 8'h00);
            cf = x[16];
         end
         if (op == 13 || op == 14) cf = 1'b0;
         gr(1'b0, 3'h1, 16'h0); check(q[15:0], x[15:0]);
      end
      gr(1'b1, 3'h1, 16'h8001); gr(1'b1, 3'h2, 16'h7FFF);
      run(cmd(3, 1'b1, 1'b0, 3'h0, 4'h1, 4'h2), 16'h0); check(q[7:4], 4'b0101);
      // Decimal fixes: 38+25 gives 5D, fixed to 63; 42-15 gives 2D, fixed to 27
      for (int k = 0; k < 2; k++) begin
         gr(1'b1, 3'h1, k ? 16'h0042 : 16'h0038); gr(1'b1, 3'h2, k ? 16'h0015 : 16'h0025);
         run(cmd(k ? 5'h4 : 5'h3, 1'b0, 1'b0, 3'h0, 4'h9, 4'hA), 16'h0);
         run(cmd(k ? 5'hC : 5'hB, 1'b0, 1'b0, 3'h0, 4'h9, 4'h9), 16'h0);
         gr(1'b0, 3'h1, 16'h0); check(q[15:0], k ? 16'h0027 : 16'h0063);
      end
      $display("arithmetic test done");
      gr(1'b1, 3'h3, 16'hA55A); gr(1'b1, 3'h7, 16'h0101);
      run(cmd(1, 1'b1, 1'b1, 3'h4, 4'h3, 4'h3), 16'h0); check(mem.m[16'h00FE], 16'hA55A);
      gr(1'b0, 3'h7, 16'h0); check(q[15:0], 16'h00FF);
      run(cmd(2, 1'b1, 1'b0, 3'h3, 4'h4, 4'h4), 16'h0);
      gr(1'b0, 3'h4, 16'h0); check(q[15:0], 16'hA55A);
      gr(1'b0, 3'h7, 16'h0); check(q[15:0], 16'h0101);
      run(cmd(0, 1'b0, 1'b1, 3'h5, 4'hB, 4'hB), 16'h0033); check(mem.m[16'hFF33], 16'h005A);
      run(cmd(0, 1'b1, 1'b1, 3'h6, 4'h3, 4'h3), 16'h0201); check(mem.m[16'h0200], 16'hA55A);
      $display("memory test done");
      run(cmd(0, 1'b1, 1'b1, 3'h5, 4'h3, 4'h3), 16'h0); check(q[STAT_ERR_BIT], 1'b1);
      run(cmd(4, 1'b0, 1'b0, 3'h7, 4'h9, 4'hA), 16'h0); check(q[STAT_ERR_BIT], 1'b1);
      run(cmd(3, 1'b1, 1'b0, 3'h7, 4'h1, 4'h2), 16'h0); check(q[STAT_ERR_BIT], 1'b1);
      run(cmd(15, 1'b1, 1'b0, 3'h7, 4'h1, 4'h2), 16'h0); check(q[STAT_ERR_BIT], 1'b1);
      $display("refusal test done");
      print_verdict();
   end
endmodule : cpu_transfer_arith_unit_tb
`default_nettype wire
